// ### common/sbcw_regs.vh
// Constants for the safety-bus control and status word block.
// Assumes a 16-byte safety message moved one byte per valid strobe.
`ifndef SBCW_REGS_VH
`define SBCW_REGS_VH

// Message layout
`define SBCW_MSG_BYTES      5'h10
`define SBCW_MSG_LAST       4'hf
`define SBCW_PROC_LAST      4'hb
`define SBCW_CTRL_BYTE      4'hc
`define SBCW_CRC_FIRST      4'hd

// Control word bit positions
`define SBCW_CW_STO         0
`define SBCW_CW_SS1         1
`define SBCW_CW_SS2         2
`define SBCW_CW_SLS_LO      3
`define SBCW_CW_SDI_POS     7
`define SBCW_CW_SDI_NEG     8
`define SBCW_CW_ENCONF      9
`define SBCW_CW_SLI         10
`define SBCW_CW_OMS         11
`define SBCW_CW_SLP_LO      12
`define SBCW_CW_ACK_RL      16
`define SBCW_CW_FLT_ACK     17
`define SBCW_CW_SOS         18
`define SBCW_CW_RMS         19
`define SBCW_CW_HOM_START   20
`define SBCW_CW_HOM_LOAD    21
`define SBCW_CW_STANDSTILL  22
`define SBCW_CW_ESTOP       23
`define SBCW_CW_SOUT1       24
`define SBCW_CW_SBC         25
`define SBCW_CW_USED_MASK   32'h03ffffff

// Status word bit positions
`define SBCW_SW_STO         0
`define SBCW_SW_SS1         1
`define SBCW_SW_SS2         2
`define SBCW_SW_SLS_LO      3
`define SBCW_SW_SDI_POS     7
`define SBCW_SW_SDI_NEG     8
`define SBCW_SW_ENCONF      9
`define SBCW_SW_SLI         10
`define SBCW_SW_STANDSTILL  16
`define SBCW_SW_SLS_MON_LO  17
`define SBCW_SW_SDI_POS_MON 21
`define SBCW_SW_SDI_NEG_MON 22

// Reset values: all low-active requests asserted, edge history high
`define SBCW_CW_RESET       32'h00000000
`define SBCW_EDGE_RESET     6'h3f

// Delays, counted in safety-bus cycles
`define SBCW_SS1_STOP_CYC   8'h0a
`define SBCW_SS2_STOP_CYC   8'h0a
`define SBCW_SLS_BRAKE_CYC  8'h05
`define SBCW_SDI_DELAY_CYC  8'h03

`endif

// ### rtl/sbcw_delay.v
// Delay timer counting safety-bus cycles while its function is armed.
// Assumes tick is a one-cycle pulse per bus cycle; disarming clears it.
`timescale 1ns/1ps
module sbcw_delay #(
   parameter [7:0] COUNT = 8'h01
)(
   // Clock and reset
   input  wire       clk,
   input  wire       sys_rst,
   // Control
   input  wire       tick,
   input  wire       arm,
   // Result
   output reg        done
);
   reg  [7:0] count;

   // Count armed cycles; saturate at the target so done holds
   always @(posedge clk)
   begin
      if (sys_rst || !arm)
      begin
         count <= 8'h00;
         done  <= 1'b0;
      end
      else if (tick && !done)
      begin
         count <= count + 8'h01;
         done  <= (count + 8'h01) >= COUNT;
      end
   end
endmodule // sbcw_delay

// ### rtl/sbcw_frame_rx.v
// Collects one incoming 16-byte safety message, byte by byte.
// Assumes rx_start marks byte 0; checksum checking is done outside.
`timescale 1ns/1ps
`include "sbcw_regs.vh"
module sbcw_frame_rx (
   // Clock and reset
   input  wire        clk,
   input  wire        sys_rst,
   // Byte stream
   input  wire        rx_valid,
   input  wire        rx_start,
   input  wire [7:0]  rx_byte,
   // Assembled message
   output reg         frame_done,
   output reg  [31:0] frame_word,
   output reg  [7:0]  frame_ctrl
);
   reg  [3:0]  idx;
   reg         in_frame;
   reg  [31:0] word_acc;
   reg  [7:0]  ctrl_acc;
   wire [3:0]  pos;

   // A start strobe on a valid byte always resynchronises to byte 0
   assign pos = rx_start ? 4'h0 : idx;

   // Byte collection; output only moves at the last byte
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         idx        <= 4'h0;
         in_frame   <= 1'b0;
         word_acc   <= 32'h00000000;
         ctrl_acc   <= 8'h00;
         frame_done <= 1'b0;
         frame_word <= `SBCW_CW_RESET;
         frame_ctrl <= 8'h00;
      end
      else
      begin
         frame_done <= 1'b0;
         if (rx_valid && (in_frame || rx_start))
         begin
            if (pos < 4'h4)
               word_acc[pos[1:0]*8 +: 8] <= rx_byte;
            if (pos == `SBCW_CTRL_BYTE)
               ctrl_acc <= rx_byte;
            if (pos == `SBCW_MSG_LAST)
            begin
               in_frame   <= 1'b0;
               idx        <= 4'h0;
               frame_done <= 1'b1;
               frame_word <= word_acc;
               frame_ctrl <= ctrl_acc;
            end
            else
            begin
               in_frame <= 1'b1;
               idx      <= pos + 4'h1;
            end
         end
      end
   end
endmodule // sbcw_frame_rx

// ### rtl/sbcw_core.v
// Safety-bus control word decoder and status word builder.
// Assumes byte streams from the fieldbus layer; checksums handled outside.
// How it works
// - Control bit 0 low requests safe torque off.
// - Bits 1 and 2 low request safe stop one and two.
// - Bits 3 to 6 low request speed-limit stages one to four.
// - Bit 7 low requests positive, bit 8 low negative safe direction.
// - Bit 9 high confirms enabling; motion allowed in special operation.
// - Bit 10 low requests limited increment; bit 18 low operating stop.
// - Bit 11 selects normal (0) or special (1) operation.
// - Bits 12 to 15 low request position-limit stages one to four.
// - Rising bit 16 pulses restart acknowledgement.
// - Rising bit 17 pulses fault acknowledgement.
// - Bit 19 high turns repair mode on, low turns it off.
// - Rising bit 20 starts safe homing.
// - Rising bit 21 loads the home position as reference.
// - Bits 22, 23, 25 low request standstill, emergency stop, brake.
// - Bit 24 high drives safe output one on.
// - Status bit 0 high when torqueless, directly or after stop one.
// - Status bit 1 high while stop one runs; completion sets bit 0.
// - Status bit 2 high while stop two runs; its end sets bit 16.
// - Status bits 3-6 follow speed stages; monitored bits 17-20 after braking.
// - Status bits 7, 8 follow directions; bits 21, 22 after delay.
// - Status bit 9 reports enabling confirm during special operation.
// - Messages are 16 bytes: process data, control/status, checksum.
// - Byte 12 carries control byte inbound, status byte outbound.
`timescale 1ns/1ps
`include "sbcw_regs.vh"
module sbcw_core (
   // Clock and reset
   input  wire        clk,
   input  wire        sys_rst,
   // Inbound message bytes
   input  wire        rx_valid,
   input  wire        rx_start,
   input  wire [7:0]  rx_byte,
   // Outbound message bytes
   output wire        tx_valid,
   input  wire        tx_ready,
   output reg         tx_start,
   output reg  [7:0]  tx_byte,
   // Protocol byte and checksum from the protocol layer; control byte and cycle tick back to it
   input  wire [7:0]  tx_status_byte,
   input  wire [23:0] tx_crc,
   output wire [7:0]  rx_ctrl_byte,
   output reg         cycle_tick,
   // Level requests to the safety functions
   output reg         safe_torque_off,
   output reg         safe_stop_one,
   output reg         safe_stop_two,
   output reg  [3:0]  safely_limited_speed,
   output reg         safe_direction_positive,
   output reg         safe_direction_negative,
   output reg         enabling_confirm,
   output reg         safely_limited_increment,
   output reg         operating_mode_select,
   output reg  [3:0]  safely_limited_position,
   output reg         safe_operating_stop,
   output reg         repair_mode_select,
   output reg         standstill_select_function,
   output reg         emergency_stop_select,
   output reg         safe_output_one,
   output reg         safe_brake_control,
   // One-cycle event requests
   output reg         ack_relaunch,
   output reg         fault_ack,
   output reg         safe_homing_start,
   output reg         safe_homing_load,
   // Status word as sent back
   output reg  [31:0] status_word
);
   // Serialiser states
   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_SEND = 2'b01;
   localparam [1:0] ST_WAIT = 2'b10;

   wire        frame_done;
   wire [31:0] frame_word;
   wire [31:0] cw;
   wire [7:0]  arm;
   wire [7:0]  elapsed;
   reg  [5:0]  edge_prev;
   wire [5:0]  edge_now;
   wire [5:0]  edge_rise;
   reg  [31:0] next_status;
   reg  [1:0]  state;
   reg  [3:0]  tx_idx;
   reg  [31:0] tx_word;
   reg  [7:0]  tx_stat;
   reg  [23:0] tx_chk;
   genvar      gi;

   // Per-timer delay count, indexed as the arm vector
   function [7:0] delay_of;
      input integer n;
      begin
         if (n == 0)
            delay_of = `SBCW_SS1_STOP_CYC;
         else if (n == 1)
            delay_of = `SBCW_SS2_STOP_CYC;
         else if (n < 6)
            delay_of = `SBCW_SLS_BRAKE_CYC;
         else
            delay_of = `SBCW_SDI_DELAY_CYC;
      end
   endfunction

   // Inbound message assembly
   // 16-byte message
   sbcw_frame_rx u_rx (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .rx_valid   (rx_valid),
      .rx_start   (rx_start),
      .rx_byte    (rx_byte),
      .frame_done (frame_done),
      .frame_word (frame_word),
      .frame_ctrl (rx_ctrl_byte)
   );

   // Only the defined bits reach the decode
   // reserved bits masked
   assign cw = frame_word & `SBCW_CW_USED_MASK;

   // Edge-triggered bits in one group: relaunch, fault, homing start, homing load
   assign edge_now = {cw[`SBCW_CW_HOM_LOAD], cw[`SBCW_CW_HOM_START],
                      cw[`SBCW_CW_FLT_ACK], cw[`SBCW_CW_ACK_RL], 2'b00};
   assign edge_rise = edge_now & ~edge_prev;

   // Level decode, updated once per safety-bus cycle
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         cycle_tick                 <= 1'b0;
         safe_torque_off            <= 1'b1;
         safe_stop_one              <= 1'b1;
         safe_stop_two              <= 1'b1;
         safely_limited_speed       <= 4'hf;
         safe_direction_positive    <= 1'b1;
         safe_direction_negative    <= 1'b1;
         enabling_confirm           <= 1'b0;
         safely_limited_increment   <= 1'b1;
         operating_mode_select      <= 1'b0;
         safely_limited_position    <= 4'hf;
         safe_operating_stop        <= 1'b1;
         repair_mode_select         <= 1'b0;
         standstill_select_function <= 1'b1;
         emergency_stop_select      <= 1'b1;
         safe_output_one            <= 1'b0;
         safe_brake_control         <= 1'b1;
      end
      else
      begin
         cycle_tick <= frame_done;
         if (frame_done)
         begin
            safe_torque_off            <= ~cw[`SBCW_CW_STO];
            safe_stop_one              <= ~cw[`SBCW_CW_SS1];
            safe_stop_two              <= ~cw[`SBCW_CW_SS2];
            safely_limited_speed       <= ~cw[`SBCW_CW_SLS_LO +: 4];
            safe_direction_positive    <= ~cw[`SBCW_CW_SDI_POS];
            safe_direction_negative    <= ~cw[`SBCW_CW_SDI_NEG];
            enabling_confirm           <= cw[`SBCW_CW_ENCONF];
            safely_limited_increment   <= ~cw[`SBCW_CW_SLI];
            safe_operating_stop        <= ~cw[`SBCW_CW_SOS];
            operating_mode_select      <= cw[`SBCW_CW_OMS];
            safely_limited_position    <= ~cw[`SBCW_CW_SLP_LO +: 4];
            repair_mode_select         <= cw[`SBCW_CW_RMS];
            standstill_select_function <= ~cw[`SBCW_CW_STANDSTILL];
            emergency_stop_select      <= ~cw[`SBCW_CW_ESTOP];
            safe_brake_control         <= ~cw[`SBCW_CW_SBC];
            safe_output_one            <= cw[`SBCW_CW_SOUT1];
         end
      end
   end

   // Edge events. History starts high so a bit already set after reset
   // does not fire; the controller must drop and raise it again.
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         edge_prev         <= `SBCW_EDGE_RESET;
         ack_relaunch      <= 1'b0;
         fault_ack         <= 1'b0;
         safe_homing_start <= 1'b0;
         safe_homing_load  <= 1'b0;
      end
      else
      begin
         // one sample per bus cycle catches a held bit
         if (frame_done)
            edge_prev <= edge_now;
         ack_relaunch      <= frame_done & edge_rise[2];
         fault_ack         <= frame_done & edge_rise[3];
         safe_homing_start <= frame_done & edge_rise[4];
         safe_homing_load  <= frame_done & edge_rise[5];
      end
   end

   // Timers armed by the running functions
   assign arm = {safe_direction_negative, safe_direction_positive,
                 safely_limited_speed, safe_stop_two, safe_stop_one};

   // One delay per timed function, ticked once per bus cycle
   generate
      for (gi = 0; gi < 8; gi = gi + 1)
      begin : g_delay
         sbcw_delay #(
            .COUNT (delay_of(gi))
         ) u_delay (
            .clk     (clk),
            .sys_rst (sys_rst),
            .tick    (cycle_tick),
            .arm     (arm[gi]),
            .done    (elapsed[gi])
         );
      end
   endgenerate

   // Status word assembly
   always @*
   begin
      next_status = 32'h00000000;
      // torqueless directly or after stop one
      next_status[`SBCW_SW_STO] = safe_torque_off | elapsed[0];
      // stop one running until its time elapses
      next_status[`SBCW_SW_SS1] = safe_stop_one & ~elapsed[0];
      // stop two running, then standstill monitored
      next_status[`SBCW_SW_SS2] = safe_stop_two;
      next_status[`SBCW_SW_STANDSTILL] = elapsed[1];
      // speed stages and their monitored bits
      next_status[`SBCW_SW_SLS_LO +: 4] = safely_limited_speed;
      next_status[`SBCW_SW_SLS_MON_LO +: 4] = elapsed[5:2];
      next_status[`SBCW_SW_SDI_POS] = safe_direction_positive;
      next_status[`SBCW_SW_SDI_NEG] = safe_direction_negative;
      next_status[`SBCW_SW_SDI_POS_MON] = elapsed[6];
      next_status[`SBCW_SW_SDI_NEG_MON] = elapsed[7];
      // confirm only meaningful in special operation
      next_status[`SBCW_SW_ENCONF] = operating_mode_select & enabling_confirm;
      next_status[`SBCW_SW_SLI] = safely_limited_increment;
   end

   // Status register follows decode one cycle later
   always @(posedge clk)
   begin
      if (sys_rst)
         status_word <= 32'h00000000;
      else
         status_word <= next_status;
   end

   assign tx_valid = (state == ST_SEND);

   // Reply serialiser: one message answers each inbound message that arrives while it is idle.
   // A reply still in flight when the next cycle arrives keeps its
   // snapshot; the newer status goes out with the following cycle.
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         state    <= ST_IDLE;
         tx_idx   <= 4'h0;
         tx_word  <= 32'h00000000;
         tx_stat  <= 8'h00;
         tx_chk   <= 24'h000000;
         tx_byte  <= 8'h00;
         tx_start <= 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               // Wait one cycle so the status register holds the new levels; elapsed timer bits reach it one cycle later
               if (cycle_tick)
                  state <= ST_WAIT;
            end
            ST_WAIT:
            begin
               tx_word  <= status_word;
               tx_stat  <= tx_status_byte;
               tx_chk   <= tx_crc;
               tx_idx   <= 4'h0;
               tx_byte  <= status_word[7:0];
               tx_start <= 1'b1;
               state    <= ST_SEND;
            end
            ST_SEND:
            begin
               if (tx_ready)
               begin
                  tx_start <= 1'b0;
                  if (tx_idx == `SBCW_MSG_LAST)
                     state <= ST_IDLE;
                  else
                     tx_idx <= tx_idx + 4'h1;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
         if (state == ST_SEND && tx_ready && tx_idx != `SBCW_MSG_LAST)
            tx_byte <= next_byte_after(tx_idx);
      end
   end

   // Byte that follows position p in the outbound message
   function [7:0] next_byte_after;
      input [3:0] p;
      reg   [3:0] q;
      begin
         q = p + 4'h1;
         if (q < 4'h4)
            next_byte_after = tx_word[q[1:0]*8 +: 8];
         else if (q == `SBCW_CTRL_BYTE)
            next_byte_after = tx_stat;
         else if (q >= `SBCW_CRC_FIRST)
            next_byte_after = tx_chk[(q - `SBCW_CRC_FIRST)*8 +: 8];
         else
            next_byte_after = 8'h00;
      end
   endfunction
endmodule // sbcw_core

// ### verif/sbcw_checker.sv
// Checker on the decoder's top-level ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module sbcw_checker (
   // Clock and reset
   input logic        clk,
   input logic        sys_rst,
   // Message timing and reply stream
   input logic        cycle_tick,
   input logic        tx_valid,
   input logic        tx_ready,
   input logic        tx_start,
   input logic [7:0]  tx_byte,
   // Requests and status
   input logic        safe_torque_off,
   input logic        safe_stop_one,
   input logic [3:0]  safely_limited_speed,
   input logic        safe_direction_positive,
   input logic        safe_direction_negative,
   input logic        enabling_confirm,
   input logic        operating_mode_select,
   input logic        safely_limited_increment,
   input logic        ack_relaunch,
   input logic        fault_ack,
   input logic [31:0] status_word
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   // Events: tick-aligned single pulses
   property p_ack_event; ack_relaunch |-> cycle_tick ##1 !ack_relaunch; endproperty
   a_ack_event: assert property (p_ack_event)
      else $error("ack pulse bad");
   property p_fault_event; fault_ack |-> cycle_tick ##1 !fault_ack; endproperty
   a_fault_event: assert property (p_fault_event)
      else $error("fault pulse bad");
   // Levels move only on a tick
   property p_level_hold;
      !cycle_tick && !$past(sys_rst) |->
         $stable(safe_torque_off) && $stable(safely_limited_speed) && $stable(enabling_confirm);
   endproperty
   a_level_hold: assert property (p_level_hold)
      else $error("level moved");
   // Status trails requests by a cycle
   property p_sto_status; !$past(sys_rst) && $past(safe_torque_off) |-> status_word[0]; endproperty
   a_sto_status: assert property (p_sto_status)
      else $error("bit 0 low");
   property p_ss1_status;
      !$past(sys_rst) && $past(safe_stop_one) |-> status_word[1] || status_word[0];
   endproperty
   a_ss1_status: assert property (p_ss1_status)
      else $error("bit 1 low");
   property p_sls_status;
      !$past(sys_rst) |-> status_word[6:3] == $past(safely_limited_speed);
   endproperty
   a_sls_status: assert property (p_sls_status)
      else $error("bits 6:3 wrong");
   property p_dir_status;
      !$past(sys_rst) |->
         status_word[8:7] == $past({safe_direction_negative, safe_direction_positive});
   endproperty
   a_dir_status: assert property (p_dir_status)
      else $error("direction flags wrong");
   property p_enconf_status;
      !$past(sys_rst) |->
         status_word[9] == $past(enabling_confirm && operating_mode_select);
   endproperty
   a_enconf_status: assert property (p_enconf_status)
      else $error("bit 9 wrong");
   property p_sli_status;
      !$past(sys_rst) |-> status_word[10] == $past(safely_limited_increment);
   endproperty
   a_sli_status: assert property (p_sli_status)
      else $error("bit 10 wrong");
   // A stalled reply byte must not move; a new reply opens with the start flag
   property p_tx_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte); endproperty
   a_tx_hold: assert property (p_tx_hold)
      else $error("byte moved in stall");
   property p_tx_first; $rose(tx_valid) |-> tx_start; endproperty
   a_tx_first: assert property (p_tx_first)
      else $error("no start on byte 0");

   // Main scenarios reached
   c_ack: cover property (ack_relaunch && fault_ack);
   c_ss1_done: cover property (status_word[0] && !status_word[1] && status_word[16]);
   c_stall: cover property (tx_valid && !tx_ready);
   c_dir_mon: cover property (status_word[21]);
endmodule // sbcw_checker

// ### verif/sbcw_plc_model.sv
// Safety controller model: sends 16-byte control messages, collects replies.
// Assumes the bench calls send and sets slow for a stalling reader.
`timescale 1ns/1ps
module sbcw_plc_model #(
   parameter [7:0]  STAT = 8'h5a,     // Protocol status byte, arbitrary
   parameter [23:0] CRC  = 24'hc3b2a1 // Checksum bytes, arbitrary
)(
   // Clock
   input  wire        clk,
   // Control message bytes
   output reg         rx_valid = 1'b0,
   output reg         rx_start = 1'b0,
   output reg  [7:0]  rx_byte = 8'h00,
   // Reply bytes
   input  wire        tx_valid,
   input  wire        tx_start,
   input  wire [7:0]  tx_byte,
   output reg         tx_ready = 1'b0,
   // Protocol fields for the reply
   output wire [7:0]  tx_status_byte,
   output wire [23:0] tx_crc
);
   reg [7:0] reply [0:15];
   reg [4:0] reply_cnt = 5'h00;
   reg       slow = 1'b0;

   assign tx_status_byte = STAT;
   assign tx_crc         = CRC;

   // Slow reader stalls every other cycle
   always @(posedge clk)
      tx_ready <= slow ? ~tx_ready : 1'b1;

   // Collect reply; byte zero restarts, extra bytes push the count past 16
   always @(posedge clk)
      if (tx_valid && tx_ready)
      begin
         reply[tx_start ? 4'h0 : reply_cnt[3:0]] <= tx_byte;
         reply_cnt <= tx_start ? 5'h01 : reply_cnt + 5'h01;
      end

   task send(input [31:0] cw, input [7:0] ctrl, input integer n);
      integer   i;
      reg [7:0] b;
      begin
         b = 8'h00;
         for (i = 0; i < n; i = i + 1)
         begin
            b = (i < 4) ? cw[8*i +: 8] : (i == 12) ? ctrl : {4'ha, i[3:0]};
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_start <= (i == 0);
            rx_byte  <= b;
         end
         // Released line shows the inverse rather than a stale byte
         @(posedge clk);
         rx_valid <= 1'b0;
         rx_start <= 1'b0;
         rx_byte  <= ~b;
      end
   endtask
endmodule // sbcw_plc_model

// ### verif/test_sbcw_core.sv
// Self-checking bench for the decoder.
// Assumes the controller model supplies both byte streams.
`timescale 1ns/1ps
`include "sbcw_regs.vh"
`define CHK(g, e) \
   begin \
      num_checks = num_checks + 1; \
      if ((g) !== (e)) \
      begin \
         miscompares = miscompares + 1; \
         $display("wrong value at %0t: got %h expected %h", $time, g, e); \
      end \
   end
module test_sbcw_core;
   localparam [31:0] IDLE = 32'hfec4f5ff; // Nothing requested, spare bits high
   reg         clk = 1'b0;
   reg         sys_rst = 1'b1;
   integer     miscompares = 0;
   integer     num_checks = 0;
   reg  [31:0] prev;
   wire        rx_valid, rx_start, tx_valid, tx_ready, tx_start, cycle_tick;
   wire [7:0]  rx_byte, tx_byte, tx_status_byte, rx_ctrl_byte;
   wire [23:0] tx_crc;
   wire [31:0] status_word;
   wire [3:0]  safely_limited_speed, safely_limited_position;
   wire        safe_torque_off, safe_stop_one, safe_stop_two, safe_direction_positive;
   wire        safe_direction_negative, enabling_confirm, safely_limited_increment;
   wire        operating_mode_select, safe_operating_stop, repair_mode_select;
   wire        standstill_select_function, emergency_stop_select, safe_output_one;
   wire        safe_brake_control, ack_relaunch, fault_ack, safe_homing_start, safe_homing_load;
   wire [21:0] lv = {safe_stop_two, safe_stop_one, safe_torque_off, safely_limited_speed,
      safe_direction_negative, safe_direction_positive, enabling_confirm,
      safely_limited_increment, operating_mode_select, safely_limited_position,
      safe_operating_stop, repair_mode_select, emergency_stop_select,
      standstill_select_function, safe_output_one, safe_brake_control};
   wire [3:0]  ev = {safe_homing_load, safe_homing_start, fault_ack, ack_relaunch};

   sbcw_core u_dut (.clk, .sys_rst, .rx_valid, .rx_start, .rx_byte, .tx_valid, .tx_ready,
      .tx_start, .tx_byte, .tx_status_byte, .tx_crc, .rx_ctrl_byte, .cycle_tick,
      .safe_torque_off, .safe_stop_one, .safe_stop_two, .safely_limited_speed,
      .safe_direction_positive, .safe_direction_negative, .enabling_confirm,
      .safely_limited_increment, .operating_mode_select, .safely_limited_position,
      .safe_operating_stop, .repair_mode_select, .standstill_select_function,
      .emergency_stop_select, .safe_output_one, .safe_brake_control, .ack_relaunch,
      .fault_ack, .safe_homing_start, .safe_homing_load, .status_word);
   sbcw_plc_model u_plc (.clk, .rx_valid, .rx_start, .rx_byte, .tx_valid, .tx_start,
      .tx_byte, .tx_ready, .tx_status_byte, .tx_crc);

   // 200 MHz clock
   always #2.5 clk = ~clk;

   // Expected request levels
   function automatic [21:0] exp_lv(input [31:0] c);
      exp_lv = {~c[2:0], ~c[6:3], ~c[8:7], c[9], ~c[10], c[11], ~c[15:12], ~c[18], c[19],
         ~c[23:22], c[24], ~c[25]};
   endfunction
   // Expected status while no delay has run out
   function automatic [31:0] exp_st(input [31:0] c);
      exp_st = {21'h000000, ~c[10], c[9] & c[11], ~c[8:0]};
   endfunction

   task finish_test;
      begin
         $display("checks %0d miscompares %0d", num_checks, miscompares);
         if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask

   task wait_tick;
      integer n;
      begin
         n = 0;
         do
         begin
            @(posedge clk);
            #1;
            n = n + 1;
         end while (cycle_tick !== 1'b1 && n < 40);
         `CHK(cycle_tick, 1'b1)
      end
   endtask

   // One message; levels and events at the tick
   task msg(input [31:0] cw, input [7:0] ctrl);
      begin
         u_plc.send(cw, ctrl, 16);
         wait_tick;
         `CHK(lv, exp_lv(cw))
         `CHK(ev, {cw[21:20], cw[17:16]} & ~{prev[21:20], prev[17:16]})
         prev = cw;
      end
   endtask

   // Reset, also in mid-run; edge history comes back high
   task t_reset;
      begin
         @(posedge clk);
         sys_rst <= 1'b1;
         repeat (4) @(posedge clk);
         sys_rst <= 1'b0;
         repeat (2) @(posedge clk);
         #1;
         `CHK(lv, exp_lv(32'h0))
         `CHK(status_word, 32'h000005ff)
         `CHK(tx_valid, 1'b0)
         prev = 32'hffffffff;
      end
   endtask

   // Each control bit flipped alone
   task t_walk;
      integer b;
      begin
         for (b = 0; b < 26; b = b + 1)
         begin
            msg(IDLE ^ (32'h1 << b), 8'h00);
            @(posedge clk);
            #1;
            `CHK(status_word, exp_st(IDLE ^ (32'h1 << b)))
         end
      end
   endtask

   // Timed functions held until their delays end
   task t_timer;
      integer    k;
      reg [31:0] e;
      begin
         for (k = 1; k <= `SBCW_SS1_STOP_CYC; k = k + 1)
         begin
            msg(IDLE & ~32'h0000008e, 8'h00);
            repeat (3) @(posedge clk);
            #1;
            e = 32'h00000088;
            e[0] = (k >= `SBCW_SS1_STOP_CYC);
            e[1] = (k < `SBCW_SS1_STOP_CYC);
            e[16] = (k >= `SBCW_SS2_STOP_CYC);
            e[17] = (k >= `SBCW_SLS_BRAKE_CYC);
            e[21] = (k >= `SBCW_SDI_DELAY_CYC);
            `CHK(status_word & 32'h0023008b, e)
         end
      end
   endtask

   // Cut message dropped at next start
   task t_resync;
      begin
         u_plc.send(32'h0, 8'h00, 6);
         msg(IDLE, 8'h00);
      end
   endtask

   // Reply layout under a stalling reader
   task t_reply;
      integer    i;
      reg [31:0] st;
      reg [7:0]  e;
      begin
         st = exp_st(IDLE | 32'h00000a00);
         u_plc.slow = 1'b1;
         repeat (2)
         begin
            msg(IDLE | 32'h00000a00, 8'h3c);
            // Half-rate reader needs about 34 cycles
            repeat (40) @(posedge clk);
         end
         #1;
         `CHK(u_plc.reply_cnt, 5'h10)
         `CHK(status_word, st)
         `CHK(rx_ctrl_byte, 8'h3c)
         for (i = 0; i < 16; i = i + 1)
         begin
            e = (i < 4) ? st[8*i +: 8] : (i == 12) ? tx_status_byte :
               (i > 12) ? tx_crc[8*(i-13) +: 8] : 8'h00;
            `CHK(u_plc.reply[i], e)
         end
         u_plc.slow = 1'b0;
      end
   endtask

   // Main sequence
   initial
   begin
      t_reset;
      msg(IDLE | 32'h00330000, 8'h00);
      t_walk;
      t_timer;
      t_resync;
      t_reply;
      t_reset;
      msg(IDLE, 8'h00);
      msg(IDLE | 32'h00330000, 8'h00);
      finish_test;
   end

   // Watchdog
   initial
   begin
      #100000;
      miscompares = miscompares + 1;
      finish_test;
   end
endmodule // test_sbcw_core

bind sbcw_core sbcw_checker u_chk (.clk, .sys_rst, .cycle_tick, .tx_valid, .tx_ready,
   .tx_start, .tx_byte, .safe_torque_off, .safe_stop_one, .safely_limited_speed,
   .safe_direction_positive, .safe_direction_negative, .enabling_confirm,
   .operating_mode_select, .safely_limited_increment, .ack_relaunch, .fault_ack,
   .status_word);
